/* File: rtl/serial_rate_map.svh */
`ifndef SERIAL_RATE_MAP_SVH
`define SERIAL_RATE_MAP_SVH

// per-channel register window: channel index sits above these bits
`define CH_STRIDE_SHIFT 4
// register byte offsets inside one channel window
`define CARD_FMT_OFS 4'h0
`define DIVISOR_OFS 4'h4
`define MODE_OFS 4'h8
`define COUNT_OFS 4'hc

// reset values
`define CARD_FMT_RESET 8'hf2
`define DIVISOR_RESET 8'hff
`define MODE_RESET 8'h00
// format register: bits forced to one, bits software may change
`define CARD_FMT_ONES 8'hf2
`define CARD_FMT_WMASK 8'h0d

// format register fields
`define BIT_ORDER_POS 3
`define INVERT_POS 2
`define CARD_MODE_POS 0
// serial mode register fields
`define PRESCALE_LO_POS 0
`define PRESCALE_HI_POS 1
`define CPB_LO_POS 2
`define CPB_HI_POS 3
`define PARITY_ODD_POS 4
`define SEVEN_BIT_POS 6
`define SYNC_POS 7

// prescaler length per exponent code, in core clocks (2 * 4^n)
`define PRE_LEN_N0 8'h02
`define PRE_LEN_N1 8'h08
`define PRE_LEN_N2 8'h20
`define PRE_LEN_N3 8'h80
// basic clocks per bit
`define ASYNC_BASIC_PER_BIT 9'h010
`define SYNC_BASIC_PER_BIT 9'h002
`define CARD_S_00 9'h020
`define CARD_S_01 9'h040
`define CARD_S_10 9'h174
`define CARD_S_11 9'h100

// ahb-lite encodings
`define HSIZE_WORD 3'b010
`define HRESP_OKAY 1'b0

`endif

/* File: rtl/serial_rate_pkg.sv */
`include "serial_rate_map.svh"

package serial_rate_pkg;

    // line mode, one-hot
    typedef enum logic [2:0] {
        MODE_ASYNC = 3'b001,
        MODE_SYNC = 3'b010,
        MODE_CARD = 3'b100
    } mode_e;

    // decoded register address
    typedef struct packed {
        logic hit;
        logic [2:0] ch;
        logic [3:0] ofs;
    } addr_dec_s;

    // prescaler length from the two-bit exponent code
    function automatic logic [7:0] prescale_len(input logic [1:0] code);
        logic [7:0] len;
        len = `PRE_LEN_N0;
        case (code)
            2'b00: len = `PRE_LEN_N0;
            2'b01: len = `PRE_LEN_N1;
            2'b10: len = `PRE_LEN_N2;
            default: len = `PRE_LEN_N3;
        endcase
        return len;
    endfunction

    // basic clocks that make one bit time
    function automatic logic [8:0] basic_per_bit(input mode_e mode, input logic [1:0] cpb);
        logic [8:0] s;
        s = `ASYNC_BASIC_PER_BIT;
        case (mode)
            MODE_SYNC: s = `SYNC_BASIC_PER_BIT;
            MODE_CARD: begin
                case (cpb)
                    2'b00: s = `CARD_S_00;
                    2'b01: s = `CARD_S_01;
                    2'b10: s = `CARD_S_10;
                    default: s = `CARD_S_11;
                endcase
            end
            default: s = `ASYNC_BASIC_PER_BIT;
        endcase
        return s;
    endfunction

endpackage

/* File: rtl/bit_clock_gen.sv */
`timescale 1ns/1ps
`include "serial_rate_map.svh"

// one channel's rate generator: prescaler, divisor counter, bit counter
module bit_clock_gen (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] prescale_code,
    input wire logic [7:0] divisor,
    input wire serial_rate_pkg::mode_e mode,
    input wire logic [1:0] cpb_code,
    output logic basic_tick,
    output logic bit_tick,
    output logic [7:0] div_count
);

    logic [7:0] pre_cnt_ff;   // prescaler down-count
    logic [7:0] nxt_pre_cnt;
    logic [7:0] div_cnt_ff;   // divisor down-count
    logic [7:0] nxt_div_cnt;
    logic [8:0] bit_cnt_ff;   // basic clocks left in the bit
    logic [8:0] nxt_bit_cnt;
    logic basic_ff;
    logic nxt_basic;
    logic bit_ff;
    logic nxt_bit;

    ////////////////////////////////////////////////////////////////
    // next-state of the three counters
    always_comb begin
        nxt_pre_cnt = pre_cnt_ff - 8'h01;
        nxt_div_cnt = div_cnt_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_basic = 1'b0;
        nxt_bit = 1'b0;
        // prescaler period is 2*4^n core clocks
        if (pre_cnt_ff == 8'h00) begin
            nxt_pre_cnt = serial_rate_pkg::prescale_len(prescale_code) - 8'h01;
            // divisor taken only at reload, a write never cuts a count
            if (div_cnt_ff == 8'h00) begin
                nxt_div_cnt = divisor;
                nxt_basic = 1'b1;
            end else begin
                nxt_div_cnt = div_cnt_ff - 8'h01;
            end
        end
        // bit time: 16, 2 or s basic clocks
        if (nxt_basic) begin
            if (bit_cnt_ff == 9'h000) begin
                nxt_bit_cnt = serial_rate_pkg::basic_per_bit(mode, cpb_code) - 9'h001;
                nxt_bit = 1'b1;
            end else begin
                nxt_bit_cnt = bit_cnt_ff - 9'h001;
            end
        end
    end

    // counter registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pre_cnt_ff <= 8'h00;
            div_cnt_ff <= `DIVISOR_RESET;
            bit_cnt_ff <= 9'h000;
            basic_ff <= 1'b0;
            bit_ff <= 1'b0;
        end else begin
            pre_cnt_ff <= nxt_pre_cnt;
            div_cnt_ff <= nxt_div_cnt;
            bit_cnt_ff <= nxt_bit_cnt;
            basic_ff <= nxt_basic;
            bit_ff <= nxt_bit;
        end
    end

    assign basic_tick = basic_ff;
    assign bit_tick = bit_ff;
    assign div_count = div_cnt_ff;

endmodule

/* File: rtl/serial_bit_rate_and_card_format.sv */
`timescale 1ns/1ps
`include "serial_rate_map.svh"

module serial_bit_rate_and_card_format #(
    parameter int CH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // data paths of the shifters
    input wire logic [CH*8-1:0] tx_holding_data,
    input wire logic [CH*8-1:0] rx_shift_data,
    output logic [CH*8-1:0] tx_line_data,
    output logic [CH*8-1:0] rx_store_data,
    // per-channel control towards the shifters
    output logic [CH-1:0] msb_first,
    output logic [CH-1:0] data_invert_select,
    output logic [CH-1:0] card_mode_select,
    output logic [CH-1:0] sync_mode,
    output logic [CH-1:0] seven_bit_char,
    output logic [CH-1:0] parity_odd,
    output logic [CH-1:0] basic_clk_tick,
    output logic [CH-1:0] bit_tick
);

    // elaboration check: channel index must fit the three-bit decode field,
    // more channels would need a wider field and a longer map
    if (CH < 1 || CH > 8) begin : bad_ch
        $error("channel count must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////
    // declarations

    // bus state
    // the slave never stalls: one address phase, one data phase
    logic wr_pend_ff;          // write data phase in progress
    logic nxt_wr_pend;
    logic [31:0] wr_addr_ff;   // address held for the data phase
    logic [31:0] nxt_wr_addr;
    logic [31:0] hrdata_ff;    // read data of the current data phase
    logic [31:0] nxt_hrdata;
    logic hreadyout_ff;
    logic hresp_ff;

    // register file, one word set per channel
    // reserved format bits live in the flops as ones too
    logic [CH-1:0][7:0] card_fmt_ff;   // smart_card_format_reg
    logic [CH-1:0][7:0] nxt_card_fmt;
    logic [CH-1:0][7:0] divisor_ff;    // bit_rate_divisor
    logic [CH-1:0][7:0] nxt_divisor;
    logic [CH-1:0][7:0] mode_ff;       // serial_mode_reg
    logic [CH-1:0][7:0] nxt_mode;

    // data path registers
    // all outputs come from flops, so these mirror the ports
    logic [CH*8-1:0] tx_line_ff;
    logic [CH*8-1:0] nxt_tx_line;
    logic [CH*8-1:0] rx_store_ff;
    logic [CH*8-1:0] nxt_rx_store;
    logic [CH-1:0] msb_first_ff;
    logic [CH-1:0] nxt_msb_first;

    // generator side
    // the live counts feed the read-only count register
    serial_rate_pkg::mode_e [CH-1:0] ch_mode;   // derived line mode
    logic [CH*8-1:0] div_count;                  // live divisor counts

    // decoded addresses
    // rd_dec looks at the live address, wr_dec at the held one
    serial_rate_pkg::addr_dec_s rd_dec;
    serial_rate_pkg::addr_dec_s wr_dec;
    logic addr_phase;

    ////////////////////////////////////////////////////////////////
    // helpers
    // both decoders and the mode pick share these, so they sit here once

    // split a byte address into channel and offset, flag a hit
    // misaligned or out-of-range addresses never hit
    function automatic serial_rate_pkg::addr_dec_s decode_addr(input logic [31:0] a);
        serial_rate_pkg::addr_dec_s d;
        d.ch = a[`CH_STRIDE_SHIFT+2:`CH_STRIDE_SHIFT];
        d.ofs = a[`CH_STRIDE_SHIFT-1:0];
        d.hit = (a[31:`CH_STRIDE_SHIFT+3] == '0) && (int'(d.ch) < CH) && (a[1:0] == 2'b00);
        return d;
    endfunction

    // line mode from the format and mode bytes
    // card mode has priority, then clocked synchronous, else async
    function automatic serial_rate_pkg::mode_e line_mode(input logic [7:0] fmt, input logic [7:0] md);
        serial_rate_pkg::mode_e m;
        m = serial_rate_pkg::MODE_ASYNC;
        if (fmt[`CARD_MODE_POS]) begin
            m = serial_rate_pkg::MODE_CARD;
        end else if (md[`SYNC_POS]) begin
            m = serial_rate_pkg::MODE_SYNC;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////
    // ahb-lite slave: address phase capture and read data
    // zero wait states: hreadyout stays high, hresp stays okay
    // read data are registered at the address edge and stand one cycle
    // write address is held so the data phase can decode it

    assign addr_phase = hsel && hready && htrans[1];
    assign rd_dec = decode_addr(haddr);
    assign wr_dec = decode_addr(wr_addr_ff);

    // next bus state; reads see this cycle's write through nxt_ values
    always_comb begin
        nxt_wr_pend = addr_phase && hwrite && (hsize == `HSIZE_WORD);
        nxt_wr_addr = addr_phase ? haddr : wr_addr_ff;
        nxt_hrdata = 32'h0000_0000;
        if (addr_phase && !hwrite && rd_dec.hit) begin
            // format register with reserved bits forced high
            if (rd_dec.ofs == `CARD_FMT_OFS) begin
                nxt_hrdata = {24'h000000, nxt_card_fmt[rd_dec.ch] | `CARD_FMT_ONES};
            end else if (rd_dec.ofs == `DIVISOR_OFS) begin
                // divisor readable in every state
                nxt_hrdata = {24'h000000, nxt_divisor[rd_dec.ch]};
            end else if (rd_dec.ofs == `MODE_OFS) begin
                nxt_hrdata = {24'h000000, nxt_mode[rd_dec.ch]};
            end else if (rd_dec.ofs == `COUNT_OFS) begin
                // live counter of that channel's generator
                nxt_hrdata = {24'h000000, div_count[rd_dec.ch*8 +: 8]};
            end else begin
                // hole inside the window reads zero
                nxt_hrdata = 32'h0000_0000;
            end
        end
    end

    // bus registers; never stalls, always okay
    // hreadyout is a flop so the bus sees it straight from a register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 32'h0000_0000;
            hrdata_ff <= 32'h0000_0000;
            hreadyout_ff <= 1'b1;
            hresp_ff <= `HRESP_OKAY;
        end else begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            hrdata_ff <= nxt_hrdata;
            hreadyout_ff <= 1'b1;
            hresp_ff <= `HRESP_OKAY;
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;
    assign hrdata = hrdata_ff;

    ////////////////////////////////////////////////////////////////
    // register file: writes land at the end of the data phase
    // a read right behind a write sees the new value through nxt_
    // non-word writes and unmapped addresses are dropped, still okay
    // the live count register has no write path

    // next register values
    always_comb begin
        nxt_card_fmt = card_fmt_ff;
        nxt_divisor = divisor_ff;
        nxt_mode = mode_ff;
        if (wr_pend_ff && wr_dec.hit) begin
            if (wr_dec.ofs == `CARD_FMT_OFS) begin
                // only order, invert and card mode bits take a write
                nxt_card_fmt[wr_dec.ch] = (hwdata[7:0] & `CARD_FMT_WMASK) | `CARD_FMT_ONES;
            end else if (wr_dec.ofs == `DIVISOR_OFS) begin
                // full eight-bit value, writable at any time
                nxt_divisor[wr_dec.ch] = hwdata[7:0];
            end else if (wr_dec.ofs == `MODE_OFS) begin
                nxt_mode[wr_dec.ch] = hwdata[7:0];
            end
        end
    end

    // register flops with their reset values
    // the for loop covers every channel's set alike
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < CH; i++) begin
                card_fmt_ff[i] <= `CARD_FMT_RESET;
                divisor_ff[i] <= `DIVISOR_RESET;
                mode_ff[i] <= `MODE_RESET;
            end
        end else begin
            card_fmt_ff <= nxt_card_fmt;
            divisor_ff <= nxt_divisor;
            mode_ff <= nxt_mode;
        end
    end

    ////////////////////////////////////////////////////////////////
    // data path: order and inversion for each channel
    // one cycle of latency on both data paths
    // inversion covers the eight data bits only; the shifter forms
    // parity from parity_odd, so the sense on the line is unchanged

    // next data path values
    always_comb begin
        nxt_tx_line = tx_line_ff;
        nxt_rx_store = rx_store_ff;
        nxt_msb_first = msb_first_ff;
        for (int i = 0; i < CH; i++) begin
            // msb first only with eight-bit characters
            nxt_msb_first[i] = card_fmt_ff[i][`BIT_ORDER_POS] && !mode_ff[i][`SEVEN_BIT_POS];
            // data bits flipped both ways, parity sense left alone
            if (card_fmt_ff[i][`INVERT_POS]) begin
                nxt_tx_line[i*8 +: 8] = ~tx_holding_data[i*8 +: 8];
                nxt_rx_store[i*8 +: 8] = ~rx_shift_data[i*8 +: 8];
            end else begin
                nxt_tx_line[i*8 +: 8] = tx_holding_data[i*8 +: 8];
                nxt_rx_store[i*8 +: 8] = rx_shift_data[i*8 +: 8];
            end
        end
    end

    // data path flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_line_ff <= '0;
            rx_store_ff <= '0;
            msb_first_ff <= '0;
        end else begin
            tx_line_ff <= nxt_tx_line;
            rx_store_ff <= nxt_rx_store;
            msb_first_ff <= nxt_msb_first;
        end
    end

    assign tx_line_data = tx_line_ff;
    assign rx_store_data = rx_store_ff;
    assign msb_first = msb_first_ff;

    ////////////////////////////////////////////////////////////////
    // control bits straight from the register flops
    // the shifters read these levels directly, no extra pipeline
    // card mode wins over the sync bit in ch_mode when both are set; sync_mode still shows the raw bit

    genvar g;
    generate
        for (g = 0; g < CH; g++) begin : ctl
            assign data_invert_select[g] = card_fmt_ff[g][`INVERT_POS];
            // card mode switches the shifters and the bit length
            assign card_mode_select[g] = card_fmt_ff[g][`CARD_MODE_POS];
            assign sync_mode[g] = mode_ff[g][`SYNC_POS];
            assign seven_bit_char[g] = mode_ff[g][`SEVEN_BIT_POS];
            // parity sense comes only from the mode byte
            assign parity_odd[g] = mode_ff[g][`PARITY_ODD_POS];
            assign ch_mode[g] = line_mode(card_fmt_ff[g], mode_ff[g]);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // one independent generator per channel
    // each channel counts on its own divisor and mode byte, so
    // channels run at unrelated rates; a divisor write waits for the
    // channel's next reload and never cuts a running count

    generate
        for (g = 0; g < CH; g++) begin : gen
            bit_clock_gen u_gen (
                .core_clk(core_clk),
                .rst(rst),
                .prescale_code({mode_ff[g][`PRESCALE_HI_POS], mode_ff[g][`PRESCALE_LO_POS]}),
                .divisor(divisor_ff[g]),
                .mode(ch_mode[g]),
                .cpb_code({mode_ff[g][`CPB_HI_POS], mode_ff[g][`CPB_LO_POS]}),
                .basic_tick(basic_clk_tick[g]),
                .bit_tick(bit_tick[g]),
                .div_count(div_count[g*8 +: 8])
            );
        end
    endgenerate

endmodule

/* File: dv/serial_rate_asserts.sv */
`timescale 1ns/1ps

////////////////////////////////////////
// port checker for the rate block, channel 0
module serial_rate_asserts #(
    parameter int CH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [CH*8-1:0] tx_holding_data,
    input wire logic [CH*8-1:0] rx_shift_data,
    input wire logic [CH*8-1:0] tx_line_data,
    input wire logic [CH*8-1:0] rx_store_data,
    input wire logic [CH-1:0] msb_first,
    input wire logic [CH-1:0] data_invert_select,
    input wire logic [CH-1:0] seven_bit_char,
    input wire logic [CH-1:0] parity_odd,
    input wire logic [CH-1:0] basic_clk_tick,
    input wire logic [CH-1:0] bit_tick
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    // read address phase aimed at the format register
    logic rd_fmt;
    assign rd_fmt = hsel && hready && htrans[1] && !hwrite && (haddr == 32'h0);

    ////////////////////////////////////////
    // data path and format
    property p_seven_lsb;
        seven_bit_char[0] && $past(seven_bit_char[0]) |-> !msb_first[0];
    endproperty
    a_seven_lsb: assert property (p_seven_lsb) else $error("msb first with seven-bit chars");
    property p_inv_tx;
        !$past(rst) |-> tx_line_data[7:0] == ($past(tx_holding_data[7:0]) ^ {8{$past(data_invert_select[0])}});
    endproperty
    a_inv_tx: assert property (p_inv_tx) else $error("transmit data sense wrong");
    property p_inv_rx;
        !$past(rst) |-> rx_store_data[7:0] == ($past(rx_shift_data[7:0]) ^ {8{$past(data_invert_select[0])}});
    endproperty
    a_inv_rx: assert property (p_inv_rx) else $error("receive data sense wrong");
    property p_parity_keep;
        $changed(data_invert_select[0]) |-> $stable(parity_odd[0]);
    endproperty
    a_parity_keep: assert property (p_parity_keep) else $error("parity sense moved with invert");

    ////////////////////////////////////////
    // registers and bus
    property p_rd_fmt;
        rd_fmt |=> hrdata[7:4] == 4'hf && hrdata[1];
    endproperty
    a_rd_fmt: assert property (p_rd_fmt) else $error("format reserved bits not one");
    property p_hi_zero;
        hrdata[31:8] == 24'h0;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("read data above bit 7");
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not okay");

    ////////////////////////////////////////
    // generator ticks
    property p_tick_pulse;
        basic_clk_tick[0] |=> !basic_clk_tick[0];
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("basic tick too wide");
    property p_bit_on_basic;
        bit_tick[0] |-> basic_clk_tick[0];
    endproperty
    a_bit_on_basic: assert property (p_bit_on_basic) else $error("bit tick off basic tick");
endmodule

bind serial_bit_rate_and_card_format serial_rate_asserts #(.CH(CH)) u_chk (.core_clk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .tx_holding_data, .rx_shift_data, .tx_line_data,
    .rx_store_data, .msb_first, .data_invert_select, .seven_bit_char, .parity_odd, .basic_clk_tick, .bit_tick);

/* File: dv/serial_peer_model.sv */
`timescale 1ns/1ps

////////////////////////////////////////
// far-side peer: a new received byte each bit time
module serial_peer_model #(
    parameter int CH = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [CH-1:0] bit_tick,
    output logic [CH*8-1:0] rx_bytes
);
    logic [CH*8-1:0] rx_ff; // byte shown per channel
    logic [CH*8-1:0] nxt_rx_ff;
    // each channel steps on its own bit time
    always_comb begin
        nxt_rx_ff = rx_ff;
        for (int i = 0; i < CH; i++) begin
            if (bit_tick[i]) begin
                nxt_rx_ff[i*8 +: 8] = {rx_ff[i*8 +: 7], ~rx_ff[i*8+7]};
            end
        end
    end
    // register only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_ff <= {CH{8'h3c}};
        end else begin
            rx_ff <= nxt_rx_ff;
        end
    end
    assign rx_bytes = rx_ff;
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps

////////////////////////////////////////
// bench for the rate and format block
module tb_top;
    logic core_clk, rst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] tx_holding_data, rx_shift_data, tx_line_data, rx_store_data;
    logic [1:0] msb_first, data_invert_select, card_mode_select, sync_mode, seven_bit_char, parity_odd;
    logic [1:0] basic_clk_tick, bit_tick;
    int error_cnt, total_checks, cyc;

    serial_bit_rate_and_card_format #(.CH(2)) u_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_holding_data, .rx_shift_data,
        .tx_line_data, .rx_store_data, .msb_first, .data_invert_select, .card_mode_select, .sync_mode,
        .seven_bit_char, .parity_odd, .basic_clk_tick, .bit_tick);
    serial_peer_model #(.CH(2)) u_peer (.core_clk, .rst, .bit_tick, .rx_bytes(rx_shift_data));

    ////////////////////////////////////////
    // 200 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            wrap_up();
        end
    end

    ////////////////////////////////////////
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb_xfer(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb_xfer(a, 1'b0, 32'h0, q);
        check(what, q, exp);
    endtask

    // cycles between bit ticks and basic ticks within one bit
    task automatic measure(input int ch, input int bit_exp, input int per_exp);
        int c, b;
        repeat (3) begin
            do @(posedge core_clk); while (bit_tick[ch] !== 1'b1);
        end
        c = 0;
        b = 0;
        do begin
            @(posedge core_clk);
            c++;
            if (basic_clk_tick[ch] === 1'b1) b++;
        end while (bit_tick[ch] !== 1'b1);
        check("bit period", c, bit_exp);
        check("basic per bit", b, per_exp);
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_regs();
        logic [7:0] vals [4] = '{8'h00, 8'h01, 8'h80, 8'hff};
        rd_chk("format reset", 32'h0, 32'hf2);
        rd_chk("divisor reset", 32'h4, 32'hff);
        rd_chk("divisor1 reset", 32'h14, 32'hff);
        wr(32'h0, 32'h0);
        rd_chk("format ones", 32'h0, 32'hf2);
        wr(32'h0, 32'hff);
        rd_chk("format all", 32'h0, 32'hff);
        foreach (vals[i]) begin
            wr(32'h4, {24'h0, vals[i]});
            rd_chk("divisor rw", 32'h4, {24'h0, vals[i]});
        end
        wr(32'h14, 32'h33);
        rd_chk("divisor own", 32'h4, 32'hff);
        wr(32'h24, 32'h77);
        rd_chk("unmapped", 32'h24, 32'h0);
    endtask

    task automatic t_format();
        logic [15:0] s;
        wr(32'h0, 32'h0c);
        wr(32'h8, 32'h00);
        tx_holding_data <= 16'h1ea5;
        repeat (2) @(posedge core_clk);
        check("msb first", msb_first[0], 1'b1);
        check("card off", card_mode_select[0], 1'b0);
        check("invert flag", data_invert_select[0], 1'b1);
        check("tx inverted", tx_line_data, 16'h1e5a);
        s = rx_shift_data;
        @(posedge core_clk);
        check("rx inverted", rx_store_data, {s[15:8], ~s[7:0]});
        wr(32'h8, 32'h40);
        repeat (2) @(posedge core_clk);
        check("seven lsb", msb_first[0], 1'b0);
        check("seven flag", seven_bit_char[0], 1'b1);
        wr(32'h8, 32'h10);
        repeat (2) @(posedge core_clk);
        check("parity odd", parity_odd[0], 1'b1);
        wr(32'h0, 32'h08);
        repeat (2) @(posedge core_clk);
        check("parity kept", parity_odd[0], 1'b1);
        check("tx plain", tx_line_data, 16'h1ea5);
        check("msb again", msb_first[0], 1'b1);
        wr(32'h0, 32'h01);
        repeat (2) @(posedge core_clk);
        check("card on", card_mode_select[0], 1'b1);
    endtask

    task automatic t_rates();
        int s_tab [4] = '{32, 64, 372, 256};
        wr(32'h0, 32'h00);
        wr(32'h4, 32'h01);
        wr(32'h14, 32'h00);
        wr(32'h18, 32'h00);
        for (int n = 0; n < 4; n++) begin
            wr(32'h8, n);
            measure(0, 64 << (2 * n), 16);
        end
        measure(1, 32, 16);
        wr(32'h8, 32'h81);
        measure(0, 32, 2);
        check("sync flag", sync_mode[0], 1'b1);
        wr(32'h0, 32'h01);
        for (int c = 0; c < 4; c++) begin
            wr(32'h8, c << 2);
            measure(0, 4 * s_tab[c], s_tab[c]);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // main sequence
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        tx_holding_data = 16'h0;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_regs();
        t_format();
        t_rates();
        wrap_up();
    end
endmodule
